// [core/cursor_adjust_regeneration_consts.svh]
// Purpose: constants for cursor adjustment during buffer regeneration
// Assumes: one 125 MHz clock, buffer words of code, cursor flag, parity
// Notes:   included by bare name; definitions only
// Function
// - Flag plus pending key in unprotected mode halts stepping, display.
// - Buffer cycle: clear data, counter to address, read, step, write back.
// - Advance with flag found: counter minus one to re-read cursor word.
// - Advance: then clear flag, flip parity, write back, counter plus one.
// - Advance: then sets flag on next word, flips parity, minus one, resume.
// - Flag set, none pending: show character with cursor, no spacing first.
// - Backspace: re-read cursor word, clear flag, flip parity, minus one.
// - Backspace: set flag on previous word, flip parity, plus one, resume.
// - End of cycle: flag with jump key steps counter back one.
// - Jump: return cycle clears flag, fixes parity, writes same address.
// - Jump removal sets protect latch: no insertion this character mode.
// - Jump removal sets a pending latch for next unprotected character mode.
// - Pending jump and mode code 40 or 41: fetch word, step back one.
// - Next cycle re-reads that word, sets flag, fixes parity, writes back.
// - Point plot unblanks after deflection; line mode unblanks during it.
// - Deflection registers hold last coordinates until new ones are loaded.
// - High four coordinate bits also go to the offset correction outputs.
`ifndef CURSOR_ADJUST_REGENERATION_CONSTS_SVH
`define CURSOR_ADJUST_REGENERATION_CONSTS_SVH

`define ADDR_W          12
`define CODE_W          8
`define WORD_W          10
`define CURSOR_BIT      8
`define PARITY_BIT      9
`define COORD_W         10
`define OFFSET_W        4
`define BAC_RESET       12'h000
`define MODE_UNPROT_A   8'h40
`define MODE_UNPROT_B   8'h41
`define CLK_MHZ         125
`define POINT_UNBLANK_NS 500
`define POINT_UNBLANK_CYC ((`POINT_UNBLANK_NS * `CLK_MHZ + 999) / 1000)
`define POINT_CNT_W     7

`endif

// [core/cursor_adjust_regeneration_pkg.sv]
// Purpose: shared types for the cursor adjustment block
// Assumes: constants come from the consts header
// Notes:   enum codes are written out in binary
package cursor_adjust_regeneration_pkg;

   // steps of one buffer cycle
   typedef enum logic [2:0] {
      CYC_IDLE  = 3'b000,
      CYC_CLEAR = 3'b001,
      CYC_READ  = 3'b010,
      CYC_STEP  = 3'b011,
      CYC_WRITE = 3'b100,
      CYC_EXAM  = 3'b101
   } buf_cycle_e;

   // cursor adjustment phase applied to the next buffer cycle
   typedef enum logic [2:0] {
      ADJ_IDLE    = 3'b000,
      ADJ_REMOVE  = 3'b001,
      ADJ_INSERT  = 3'b010,
      ADJ_JREMOVE = 3'b011,
      ADJ_JINSERT = 3'b100
   } adj_phase_e;

   // keyboard cursor request waiting for service
   typedef enum logic [1:0] {
      KEY_NONE = 2'b00,
      KEY_ADV  = 2'b01,
      KEY_BKS  = 2'b10,
      KEY_JMP  = 2'b11
   } key_req_e;

endpackage : cursor_adjust_regeneration_pkg

// [core/deflection_hold.sv]
// Purpose: X/Y deflection holding registers and beam unblank control
// Assumes: deflection complete arrives from analog circuits, unsynchronised
// Notes:   point unblank length is a fixed count of clock cycles
`timescale 1ns/1ps
`include "cursor_adjust_regeneration_consts.svh"
module deflection_hold
   import cursor_adjust_regeneration_pkg::*;
(
   input  wire logic                  mclk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  load_i,
   input  wire logic [`COORD_W-1:0]   x_i,
   input  wire logic [`COORD_W-1:0]   y_i,
   input  wire logic                  point_mode_i,
   input  wire logic                  line_mode_i,
   input  wire logic                  defl_complete_i,
   output logic      [`COORD_W-1:0]   x_o,
   output logic      [`COORD_W-1:0]   y_o,
   output logic      [`OFFSET_W-1:0]  offset_x_o,
   output logic      [`OFFSET_W-1:0]  offset_y_o,
   output logic                       unblank_o,
   output logic                       busy_o
);

   localparam logic [`POINT_CNT_W-1:0] POINT_CYC =
      `POINT_CNT_W'(`POINT_UNBLANK_CYC);

   logic [2:0]              done_sync_ff;
   logic                    busy_ff;
   logic [`POINT_CNT_W-1:0] point_cnt_ff;
   logic                    done_rise;

   // stage 0 is read only by stage 1; stage 2 serves edge detection
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_sync_ff <= 3'h0;
      end else begin
         done_sync_ff <= {done_sync_ff[1:0], defl_complete_i};
      end
   end

   assign done_rise = done_sync_ff[1] & ~done_sync_ff[2];

   // coordinates stay put so the beam holds still between loads
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         x_o <= 10'h000;
         y_o <= 10'h000;
      end else if (load_i) begin
         x_o <= x_i;
         y_o <= y_i;
      end
   end

   // high-order bits 9..6 are the most significant ones
   assign offset_x_o = x_o[`COORD_W-1 -: `OFFSET_W];
   assign offset_y_o = y_o[`COORD_W-1 -: `OFFSET_W];

   // interlock: a new load wins over a completion in the same cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_ff <= 1'b0;
      end else if (load_i) begin
         busy_ff <= 1'b1;
      end else if (done_rise) begin
         busy_ff <= 1'b0;
      end
   end

   // point spot is lit only after the beam has settled
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         point_cnt_ff <= 7'h00;
      end else if (load_i) begin
         point_cnt_ff <= 7'h00;
      end else if (busy_ff && done_rise && point_mode_i) begin
         point_cnt_ff <= POINT_CYC;
      end else if (point_cnt_ff != 7'h00) begin
         point_cnt_ff <= point_cnt_ff - 7'h01;
      end
   end

   // line mode keeps the beam on for the whole travel
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         unblank_o <= 1'b0;
      end else begin
         unblank_o <= (line_mode_i && (busy_ff || load_i)) ||
                      (point_mode_i && point_cnt_ff != 7'h00);
      end
   end

   assign busy_o = busy_ff;

endmodule : deflection_hold

// [core/cursor_adjust_regeneration.sv]
// Purpose: buffer regeneration with cursor advance, backspace and jump
// Assumes: buffer memory on mclk_i, read data valid the cycle after read
// Notes:   keyboard keys are asynchronous pulses, synchronised here
`timescale 1ns/1ps
`include "cursor_adjust_regeneration_consts.svh"
module cursor_adjust_regeneration
   import cursor_adjust_regeneration_pkg::*;
(
   input  wire logic                  mclk_i,
   input  wire logic                  rst_n_i,
   // regeneration control
   input  wire logic                  regen_en_i,
   input  wire logic                  load_addr_i,
   input  wire logic [`ADDR_W-1:0]    start_addr_i,
   // display buffer memory
   output logic      [`ADDR_W-1:0]    buf_addr_o,
   output logic                       buf_rd_o,
   output logic                       buf_wr_o,
   output logic      [`WORD_W-1:0]    buf_wdata_o,
   input  wire logic [`WORD_W-1:0]    buf_rdata_i,
   // mode decoding
   input  wire logic                  char_mode_i,
   input  wire logic                  mode_code_stb_i,
   input  wire logic [`CODE_W-1:0]    mode_control_code_i,
   // keyboard cursor keys
   input  wire logic                  kbd_advance_i,
   input  wire logic                  kbd_backspace_i,
   input  wire logic                  kbd_jump_i,
   // character generator
   output logic                       char_stb_o,
   output logic      [`CODE_W-1:0]    char_code_o,
   output logic                       char_cursor_o,
   // status
   output logic      [`ADDR_W-1:0]    buffer_address_counter_o,
   output logic                       adjust_busy_o,
   output logic                       jump_pending_o,
   output logic                       jump_protect_o,
   output logic                       key_pending_o,
   // deflection
   input  wire logic                  defl_load_i,
   input  wire logic [`COORD_W-1:0]   defl_x_i,
   input  wire logic [`COORD_W-1:0]   defl_y_i,
   input  wire logic                  point_mode_i,
   input  wire logic                  line_mode_i,
   input  wire logic                  defl_complete_i,
   output logic      [`COORD_W-1:0]   defl_x_o,
   output logic      [`COORD_W-1:0]   defl_y_o,
   output logic      [`OFFSET_W-1:0]  offset_x_o,
   output logic      [`OFFSET_W-1:0]  offset_y_o,
   output logic                       unblank_o,
   output logic                       defl_busy_o
);

   buf_cycle_e          cyc_ff;
   adj_phase_e          phase_ff;
   key_req_e            req_ff;
   logic [`ADDR_W-1:0]  bac_ff;
   logic [`ADDR_W-1:0]  bar_ff;
   logic [`WORD_W-1:0]  data_ff;
   logic                unprot_ff;
   logic                first_ff;
   logic                jump_pend_ff;
   logic                jump_prot_ff;
   logic [2:0]          key_s1_ff;
   logic [2:0]          key_s2_ff;
   logic [2:0]          key_s3_ff;
   logic [2:0]          key_rise;
   logic                cursor_seen;
   logic                start_adj;
   logic                start_jins;
   logic                seq_end;
   logic                unprot_code;

   // mode codes 40 and 41 select unprotected character mode
   function automatic logic is_unprot(input logic [`CODE_W-1:0] code);
      is_unprot = (code == `MODE_UNPROT_A) || (code == `MODE_UNPROT_B);
   endfunction : is_unprot

   // cursor flag change always flips parity to keep it valid
   function automatic logic [`WORD_W-1:0] with_cursor(
      input logic [`WORD_W-1:0] w,
      input logic               c
   );
      with_cursor = {~w[`PARITY_BIT], c, w[`CODE_W-1:0]};
   endfunction : with_cursor

   assign unprot_code = is_unprot(mode_control_code_i);

   // two flops per key before anything looks at it
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_key_sync
         always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               key_s1_ff[gi] <= 1'b0;
               key_s2_ff[gi] <= 1'b0;
               key_s3_ff[gi] <= 1'b0;
            end else begin
               key_s1_ff[gi] <= (gi == 0) ? kbd_advance_i :
                                (gi == 1) ? kbd_backspace_i : kbd_jump_i;
               key_s2_ff[gi] <= key_s1_ff[gi];
               key_s3_ff[gi] <= key_s2_ff[gi];
            end
         end
         assign key_rise[gi] = key_s2_ff[gi] & ~key_s3_ff[gi];
      end
   endgenerate

   // decisions taken at the end of a buffer cycle
   assign cursor_seen = data_ff[`CURSOR_BIT];
   assign start_jins  = (cyc_ff == CYC_EXAM) && (phase_ff == ADJ_IDLE) &&
                        jump_pend_ff && first_ff && !jump_prot_ff;
   assign start_adj   = (cyc_ff == CYC_EXAM) && (phase_ff == ADJ_IDLE) &&
                        !start_jins && unprot_ff && char_mode_i &&
                        cursor_seen && (req_ff != KEY_NONE);
   assign seq_end     = (cyc_ff == CYC_EXAM) &&
                        ((phase_ff == ADJ_INSERT) ||
                         (phase_ff == ADJ_JREMOVE));

   // buffer cycle sequencer, one step per clock
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cyc_ff <= CYC_IDLE;
      end else begin
         case (cyc_ff)
            CYC_IDLE:  cyc_ff <= regen_en_i ? CYC_CLEAR : CYC_IDLE;
            CYC_CLEAR: cyc_ff <= CYC_READ;
            CYC_READ:  cyc_ff <= CYC_STEP;
            CYC_STEP:  cyc_ff <= CYC_WRITE;
            CYC_WRITE: cyc_ff <= CYC_EXAM;
            CYC_EXAM:  cyc_ff <= regen_en_i ? CYC_CLEAR : CYC_IDLE;
            default:   cyc_ff <= CYC_IDLE;
         endcase
      end
   end

   // address register takes the counter at the start of each cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bar_ff <= `BAC_RESET;
      end else if (cyc_ff == CYC_CLEAR) begin
         bar_ff <= bac_ff;
      end
   end

   // data register: cleared, then loaded with the flag already edited, before write
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_ff <= 10'h000;
      end else if (cyc_ff == CYC_CLEAR) begin
         data_ff <= 10'h000;
      end else if (cyc_ff == CYC_STEP) begin
         case (phase_ff)
            ADJ_REMOVE:  data_ff <= with_cursor(buf_rdata_i, 1'b0);
            ADJ_JREMOVE: data_ff <= with_cursor(buf_rdata_i, 1'b0);
            ADJ_INSERT:  data_ff <= with_cursor(buf_rdata_i, 1'b1);
            ADJ_JINSERT: data_ff <= with_cursor(buf_rdata_i, 1'b1);
            default:     data_ff <= buf_rdata_i;
         endcase
      end
   end

   // counter: stepped mid-cycle, pulled back one at the end if needed
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bac_ff <= `BAC_RESET;
      end else if (cyc_ff == CYC_IDLE && load_addr_i) begin
         bac_ff <= start_addr_i;
      end else if (cyc_ff == CYC_STEP) begin
         case (phase_ff)
            ADJ_REMOVE:
               bac_ff <= (req_ff == KEY_BKS) ? bac_ff - 12'h001
                                             : bac_ff + 12'h001;
            ADJ_INSERT:
               bac_ff <= (req_ff == KEY_BKS) ? bac_ff + 12'h001
                                             : bac_ff - 12'h001;
            default:
               bac_ff <= bac_ff + 12'h001;
         endcase
      end else if (start_adj || start_jins) begin
         bac_ff <= bac_ff - 12'h001;
      end
   end

   // adjustment phase, advanced once per buffer cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_ff <= ADJ_IDLE;
      end else if (cyc_ff == CYC_EXAM) begin
         case (phase_ff)
            ADJ_IDLE: begin
               if (start_jins) begin
                  phase_ff <= ADJ_JINSERT;
               end else if (start_adj) begin
                  phase_ff <= (req_ff == KEY_JMP) ? ADJ_JREMOVE
                                                  : ADJ_REMOVE;
               end
            end
            ADJ_REMOVE:  phase_ff <= ADJ_INSERT;
            ADJ_INSERT:  phase_ff <= ADJ_IDLE;
            ADJ_JREMOVE: phase_ff <= ADJ_IDLE;
            ADJ_JINSERT: phase_ff <= ADJ_IDLE;
            default:     phase_ff <= ADJ_IDLE;
         endcase
      end
   end

   // one key press is held until its sequence ends; a press landing
   // on the clearing cycle is kept rather than lost
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_ff <= KEY_NONE;
      end else if ((req_ff == KEY_NONE || seq_end) && key_rise != 3'h0) begin
         req_ff <= key_rise[0] ? KEY_ADV :
                   key_rise[1] ? KEY_BKS : KEY_JMP;
      end else if (seq_end) begin
         req_ff <= KEY_NONE;
      end
   end

   // unprotected character mode and first-word marker from mode codes
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         unprot_ff <= 1'b0;
         first_ff  <= 1'b0;
      end else if (mode_code_stb_i) begin
         unprot_ff <= unprot_code;
         first_ff  <= unprot_code;
      end else if (cyc_ff == CYC_EXAM) begin
         first_ff  <= 1'b0;
      end
   end

   // jump protect lasts for the rest of the current character mode;
   // the setting event wins over a mode change in the same cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         jump_prot_ff <= 1'b0;
      end else if (seq_end && phase_ff == ADJ_JREMOVE) begin
         jump_prot_ff <= 1'b1;
      end else if (mode_code_stb_i) begin
         jump_prot_ff <= 1'b0;
      end
   end

   // pending jump reminder, dropped once the cursor is reinserted
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         jump_pend_ff <= 1'b0;
      end else if (seq_end && phase_ff == ADJ_JREMOVE) begin
         jump_pend_ff <= 1'b1;
      end else if (cyc_ff == CYC_EXAM && phase_ff == ADJ_JINSERT) begin
         jump_pend_ff <= 1'b0;
      end
   end

   // character hand-off; held back while an adjustment starts or runs
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         char_stb_o    <= 1'b0;
         char_code_o   <= 8'h00;
         char_cursor_o <= 1'b0;
      end else begin
         char_stb_o <= (cyc_ff == CYC_EXAM) && char_mode_i &&
                       (phase_ff == ADJ_IDLE) &&
                       !start_adj && !start_jins;
         if (cyc_ff == CYC_EXAM) begin
            char_code_o   <= data_ff[`CODE_W-1:0];
            char_cursor_o <= cursor_seen;
         end
      end
   end

   // memory strobes follow the cycle step directly
   assign buf_addr_o  = bar_ff;
   assign buf_rd_o    = (cyc_ff == CYC_READ);
   assign buf_wr_o    = (cyc_ff == CYC_WRITE);
   assign buf_wdata_o = data_ff;

   // status view of internal state
   assign buffer_address_counter_o = bac_ff;
   assign adjust_busy_o  = (phase_ff != ADJ_IDLE);
   assign jump_pending_o = jump_pend_ff;
   assign jump_protect_o = jump_prot_ff;
   assign key_pending_o  = (req_ff != KEY_NONE);

   // beam position and blanking
   deflection_hold u_deflection_hold (
      .mclk_i          (mclk_i),
      .rst_n_i         (rst_n_i),
      .load_i          (defl_load_i),
      .x_i             (defl_x_i),
      .y_i             (defl_y_i),
      .point_mode_i    (point_mode_i),
      .line_mode_i     (line_mode_i),
      .defl_complete_i (defl_complete_i),
      .x_o             (defl_x_o),
      .y_o             (defl_y_o),
      .offset_x_o      (offset_x_o),
      .offset_y_o      (offset_y_o),
      .unblank_o       (unblank_o),
      .busy_o          (defl_busy_o)
   );

endmodule : cursor_adjust_regeneration

// [verification/cursor_adjust_regeneration_assertions.sv]
// Purpose: port-level checks of buffer cycles and deflection holding
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached to the top module by the bind below
`timescale 1ns/1ps
`include "cursor_adjust_regeneration_consts.svh"
module cursor_adjust_regeneration_checker (
   input wire logic                  mclk_i,
   input wire logic                  rst_n_i,
   input wire logic                  load_addr_i,
   input wire logic                  buf_rd_o,
   input wire logic                  buf_wr_o,
   input wire logic [`ADDR_W-1:0]    buf_addr_o,
   input wire logic [`WORD_W-1:0]    buf_wdata_o,
   input wire logic [`WORD_W-1:0]    buf_rdata_i,
   input wire logic                  char_stb_o,
   input wire logic [`ADDR_W-1:0]    buffer_address_counter_o,
   input wire logic                  defl_load_i,
   input wire logic [`COORD_W-1:0]   defl_x_i,
   input wire logic [`COORD_W-1:0]   defl_x_o,
   input wire logic [`OFFSET_W-1:0]  offset_x_o,
   input wire logic                  line_mode_i,
   input wire logic                  unblank_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // read, one step cycle, then the write-back
   sequence rd_step_wr;
      buf_rd_o ##1 (!buf_rd_o && !buf_wr_o) ##1 buf_wr_o;
   endsequence
   rd_wr_order_a: assert property (buf_rd_o |-> rd_step_wr)
      else $error("write-back did not follow the read by two cycles");
   addr_held_a: assert property (buf_rd_o |=> $stable(buf_addr_o)[*2])
      else $error("buffer address moved inside a buffer cycle");
   code_kept_a: assert property (buf_wr_o |-> buf_wdata_o[7:0] == $past(buf_rdata_i[7:0]))
      else $error("written code differs from the word read");
   // a flag change must always come with a parity flip
   parity_track_a: assert property (buf_wr_o |-> (buf_wdata_o[9] ^ buf_wdata_o[8]) == ($past(buf_rdata_i[9]) ^ $past(buf_rdata_i[8])))
      else $error("parity not adjusted with the cursor flag");
   char_after_wr_a: assert property (char_stb_o |-> $past(buf_wr_o, 2))
      else $error("character sent without a finished buffer cycle");
   counter_step_a: assert property (!load_addr_i |=> (buffer_address_counter_o - $past(buffer_address_counter_o)) inside {12'h000, 12'h001, 12'hFFF})
      else $error("address counter moved by more than one");
   coord_hold_a: assert property (!defl_load_i |=> $stable(defl_x_o))
      else $error("deflection coordinate changed without a load");
   coord_load_a: assert property (defl_load_i |=> defl_x_o == $past(defl_x_i))
      else $error("deflection coordinate not loaded");
   offset_bits_a: assert property (offset_x_o == defl_x_o[`COORD_W-1 -: `OFFSET_W])
      else $error("offset bits differ from the high coordinate bits");
   line_unblank_a: assert property (line_mode_i && defl_load_i |-> ##[1:2] unblank_o)
      else $error("beam not unblanked during line deflection");
endmodule : cursor_adjust_regeneration_checker

bind cursor_adjust_regeneration cursor_adjust_regeneration_checker u_chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .load_addr_i(load_addr_i),
   .buf_rd_o(buf_rd_o), .buf_wr_o(buf_wr_o), .buf_addr_o(buf_addr_o),
   .buf_wdata_o(buf_wdata_o), .buf_rdata_i(buf_rdata_i),
   .char_stb_o(char_stb_o),
   .buffer_address_counter_o(buffer_address_counter_o),
   .defl_load_i(defl_load_i), .defl_x_i(defl_x_i), .defl_x_o(defl_x_o),
   .offset_x_o(offset_x_o), .line_mode_i(line_mode_i),
   .unblank_o(unblank_o));

// [verification/buffer_memory_model.sv]
// Purpose: behavioural display buffer memory beside the block
// Assumes: read data is needed only in the cycle after the read strobe
// Notes:   code equals low address bits; one word holds the cursor
`timescale 1ns/1ps
`include "cursor_adjust_regeneration_consts.svh"
module buffer_memory_model #(
   parameter logic [`ADDR_W-1:0] CURSOR_AT = 12'h005
) (
   input  wire logic                mclk_i,
   input  wire logic [`ADDR_W-1:0]  buf_addr_i,
   input  wire logic                buf_rd_i,
   input  wire logic                buf_wr_i,
   input  wire logic [`WORD_W-1:0]  buf_wdata_i,
   output logic      [`WORD_W-1:0]  buf_rdata_o
);
   logic [`WORD_W-1:0] mem [0:(1 << `ADDR_W)-1];
   // parity starts equal to the flag so a flip keeps them paired
   initial begin
      for (int i = 0; i < (1 << `ADDR_W); i++) begin
         mem[i] = {2'h0, i[7:0]};
      end
      mem[CURSOR_AT] = {2'h3, CURSOR_AT[7:0]};
      buf_rdata_o = '0;
   end
   // data lasts one cycle, then inverts so a late sample shows up
   always @(posedge mclk_i) begin
      if (buf_rd_i) begin
         buf_rdata_o <= mem[buf_addr_i];
      end else begin
         buf_rdata_o <= ~buf_rdata_o;
      end
      if (buf_wr_i) begin
         mem[buf_addr_i] <= buf_wdata_i;
      end
   end
endmodule : buffer_memory_model

// [verification/test_cursor_adjust_regeneration.sv]
// Purpose: self-checking bench for cursor moves and deflection holding
// Assumes: inputs change on the falling edge of mclk_i
// Notes:   regeneration is restarted near the cursor to keep runs short
`timescale 1ns/1ps
`include "cursor_adjust_regeneration_consts.svh"
module test_cursor_adjust_regeneration;
   import cursor_adjust_regeneration_pkg::*;
   localparam logic [11:0] CUR = 12'h005;
   logic mclk_i, rst_n_i, regen_en_i, load_addr_i, char_mode_i;
   logic mode_code_stb_i, defl_load_i, point_mode_i, line_mode_i;
   logic defl_complete_i;
   logic [2:0]  kbd;
   logic [11:0] start_addr_i, buf_addr_o, buffer_address_counter_o;
   logic [7:0]  mode_control_code_i, char_code_o;
   logic [9:0]  defl_x_i, defl_y_i, buf_rdata_i, buf_wdata_o;
   logic buf_rd_o, buf_wr_o, char_stb_o, char_cursor_o, adjust_busy_o;
   logic jump_pending_o, jump_protect_o, key_pending_o, unblank_o, defl_busy_o;
   logic [9:0]  defl_x_o, defl_y_o;
   logic [3:0]  offset_x_o, offset_y_o;
   int          bad_count = 0;
   int          checked = 0;
   cursor_adjust_regeneration DUT (.*, .kbd_advance_i(kbd[0]),
      .kbd_backspace_i(kbd[1]), .kbd_jump_i(kbd[2]));
   buffer_memory_model #(.CURSOR_AT(CUR)) u_mem (.mclk_i(mclk_i),
      .buf_addr_i(buf_addr_o), .buf_rd_i(buf_rd_o), .buf_wr_i(buf_wr_o),
      .buf_wdata_i(buf_wdata_o), .buf_rdata_o(buf_rdata_i));
   // free-running clock, 8 ns period
   always #4 mclk_i = ~mclk_i;
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // a used-up wait is a mismatch and ends the run
   task automatic give_up;
      bad_count++;
      report_and_stop;
   endtask : give_up
   // counter load is only taken while the sequencer idles
   task automatic restart(input logic [11:0] a);
      regen_en_i = 1'h0;
      repeat (8) @(negedge mclk_i);
      start_addr_i = a;
      load_addr_i = 1'h1;
      @(negedge mclk_i);
      load_addr_i = 1'h0;
      regen_en_i = 1'h1;
   endtask : restart
   task automatic mode(input logic [7:0] c);
      mode_control_code_i = c;
      mode_code_stb_i = 1'h1;
      @(negedge mclk_i);
      mode_code_stb_i = 1'h0;
   endtask : mode
   task automatic wait_low(input int sel);
      int n;
      for (n = 0; n < 600; n++) begin
         if ((sel == 0 ? key_pending_o : jump_pending_o) === 1'h0) break;
         @(negedge mclk_i);
      end
      if (n == 600) give_up();
      repeat (12) @(negedge mclk_i);
   endtask : wait_low
   // press long enough to pass the key synchroniser
   task automatic key_run(input logic [2:0] k, input logic [11:0] a);
      kbd = k;
      repeat (5) @(negedge mclk_i);
      kbd = 3'h0;
      check("key_pending", key_pending_o, 1'h1);
      restart(a);
      repeat (12) @(negedge mclk_i);
      check("adjust_busy", adjust_busy_o, 1'h1);
      wait_low(0);
      check("key_cleared", key_pending_o, 1'h0);
   endtask : key_run
   task automatic show_cursor;
      int n;
      logic [11:0] a;
      restart(CUR - 12'h001);
      for (a = CUR - 12'h001; a <= CUR + 12'h001; a++) begin
         for (n = 0; n < 40 && char_stb_o !== 1'h1; n++) @(negedge mclk_i);
         if (n == 40) give_up();
         check("char_code", char_code_o, a[7:0]);
         check("char_cursor", char_cursor_o, a == CUR);
         @(negedge mclk_i);
      end
   endtask : show_cursor
   task automatic jump_move;
      logic [15:0] cnt;
      key_run(3'h4, CUR - 12'h001);
      check("jump_removed", u_mem.mem[CUR], 10'h005);
      check("jump_protect", jump_protect_o, 1'h1);
      check("jump_pending", jump_pending_o, 1'h1);
      restart(12'h010);
      mode(8'h40);
      wait_low(1);
      cnt = 16'h0000;
      for (int i = 0; i < 32; i++) cnt += u_mem.mem[i][8];
      check("cursor_count", cnt, 16'h0001);
      check("protect_off", jump_protect_o, 1'h0);
   endtask : jump_move
   task automatic deflect;
      {line_mode_i, defl_load_i} = 2'h3;
      defl_x_i = 10'h30A; // horizontal vector, y stays at 0
      @(negedge mclk_i);
      defl_load_i = 1'h0;
      defl_y_i = 10'h1CA;
      @(negedge mclk_i);
      check("defl_y_held", defl_y_o, 10'h000);
      check("offset_x", offset_x_o, 4'hC);
      check("unblank_line", unblank_o, 1'h1);
      check("defl_busy", defl_busy_o, 1'h1);
      defl_complete_i = 1'h1;
      repeat (8) @(negedge mclk_i);
      check("unblank_end", unblank_o, 1'h0);
      check("defl_idle", defl_busy_o, 1'h0);
      {line_mode_i, point_mode_i, defl_complete_i, defl_load_i} = 4'h5;
      @(negedge mclk_i);
      defl_load_i = 1'h0;
      repeat (4) @(negedge mclk_i);
      check("point_dark", unblank_o, 1'h0);
      defl_complete_i = 1'h1;
      repeat (6) @(negedge mclk_i);
      check("point_lit", unblank_o, 1'h1);
      check("defl_y", defl_y_o, 10'h1CA);
      check("offset_y", offset_y_o, 4'h7);
   endtask : deflect
   // main sequence: reset, display, advance, backspace, jump, deflection
   initial begin
      {mclk_i, rst_n_i, regen_en_i, load_addr_i, mode_code_stb_i} = 5'h00;
      {defl_load_i, point_mode_i, line_mode_i, defl_complete_i} = 4'h0;
      char_mode_i = 1'h1;
      {kbd, start_addr_i, mode_control_code_i, defl_x_i, defl_y_i} = 43'h0;
      repeat (6) @(negedge mclk_i);
      rst_n_i = 1'h1;
      check("counter_reset", buffer_address_counter_o, 12'h000);
      mode(8'h41);
      show_cursor();
      key_run(3'h1, CUR - 12'h001);
      check("adv_remove", u_mem.mem[CUR], 10'h005);
      check("adv_insert", u_mem.mem[CUR + 1], 10'h306);
      key_run(3'h2, CUR);
      check("bks_remove", u_mem.mem[CUR + 1], 10'h006);
      check("bks_insert", u_mem.mem[CUR], 10'h305);
      jump_move();
      deflect();
      report_and_stop();
   end
endmodule : test_cursor_adjust_regeneration
